// *** mmor_consts.svh ***
// Purpose: constants for the memory-map and operand register block
// Assumes: APB with 32-bit data, byte offsets are four times the register index
// Notes: included by the two design modules, mmor_muldiv and mmor_regs
//
// Operation
// - The window control register decides how the top 1KB of program space is mapped.
// - The in-system-programming flag, bit 2, is set by hardware when the mode pins read 3.
// - That flag lets the processor tell whether the chip is in in-system-programming mode.
// - With the boot map bit (bit 1) at 1, addresses 0xFC00 to 0xFFFF fetch from ROM.
// - With the boot map bit at 0, those addresses fetch from non-volatile memory instead.
// - Bit 0 of the bank register picks program bank 0 or 1 and resets to bank 0.
// - The main operand register joins every arithmetic operation, is RW, resets to 0x00.
// - The auxiliary operand register is a plain general register when not used by MUL/DIV.
// - A multiply leaves the product high byte in the auxiliary and low byte in the main.
// - A divide takes its dividend from the auxiliary register and returns the remainder there.
// - The auxiliary operand register is an 8-bit RW register that resets to 0x00.
`ifndef MMOR_CONSTS_SVH
`define MMOR_CONSTS_SVH
`define MMOR_IDX_BANK 8'hA1
`define MMOR_IDX_WIN 8'hC0
`define MMOR_IDX_MAIN 8'hE0
`define MMOR_IDX_AUX 8'hF0
`define MMOR_BIT_ISP 2
`define MMOR_BIT_ROM 1
`define MMOR_BIT_BANK 0
`define MMOR_ROM_RST 1'b1
`define MMOR_BANK_RST 1'b0
`define MMOR_OPER_RST 8'h00
`define MMOR_ISP_CODE 2'h3
`define MMOR_WIN_BASE 16'hFC00
`define MMOR_DIV_CYCLES 8
`endif

// *** mmor_pkg.sv ***
package mmor_pkg;
   typedef enum logic [1:0] {
      MMOR_OP_NONE = 2'h0,
      MMOR_OP_MUL = 2'h1,
      MMOR_OP_DIV = 2'h3
   } mmor_op_t;
   typedef enum logic [1:0] {
      MMOR_ALU_IDLE = 2'h0,
      MMOR_ALU_RUN = 2'h1,
      MMOR_ALU_DONE = 2'h3
   } mmor_alu_state_t;
endpackage

// *** mmor_muldiv.sv ***
// Purpose: multi-cycle 8x8 multiply and 8/8 restoring divide
// Assumes: operands stable from start until done
// Notes: divide by zero gives quotient 0xFF and remainder equal to the dividend
`timescale 1ns/1ps
`include "mmor_consts.svh"
module mmor_muldiv
   import mmor_pkg::*;
(
   // Clocking
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEn,
   // Request
   input wire logic start,
   input wire mmor_op_t op,
   input wire logic [7:0] mainIn,
   input wire logic [7:0] auxIn,
   // Result
   output logic done,
   output logic [7:0] mainOut,
   output logic [7:0] auxOut
);
   mmor_alu_state_t state_q;
   logic [3:0] count_q;
   logic [15:0] acc_q;
   logic [7:0] quot_q;
   logic [8:0] trial;
   logic isDiv_q;

   assign trial = {acc_q[7:0], quot_q[7]} - {1'b0, mainIn};

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= MMOR_ALU_IDLE;
         count_q <= 4'h0;
         acc_q <= 16'h0000;
         quot_q <= 8'h00;
         isDiv_q <= 1'b0;
      end else if (clockEn) begin
         case (state_q)
            MMOR_ALU_IDLE: begin
               if (start && op != MMOR_OP_NONE) begin
                  state_q <= MMOR_ALU_RUN;
                  count_q <= 4'h0;
                  isDiv_q <= (op == MMOR_OP_DIV);
                  acc_q <= 16'h0000;
                  // Divide shifts the dividend (aux) through quot_q
                  quot_q <= auxIn;
               end
            end
            MMOR_ALU_RUN: begin
               if (isDiv_q) begin
                  if (!trial[8]) begin
                     acc_q <= {8'h00, trial[7:0]};
                     quot_q <= {quot_q[6:0], 1'b1};
                  end else begin
                     acc_q <= {8'h00, acc_q[6:0], quot_q[7]};
                     quot_q <= {quot_q[6:0], 1'b0};
                  end
               end else if (mainIn[count_q[2:0]]) begin
                  acc_q <= acc_q + ({8'h00, auxIn} << count_q[2:0]);
               end
               count_q <= count_q + 4'h1;
               if (count_q == 4'(`MMOR_DIV_CYCLES - 1)) begin
                  state_q <= MMOR_ALU_DONE;
               end
            end
            MMOR_ALU_DONE: state_q <= MMOR_ALU_IDLE;
            default: state_q <= MMOR_ALU_IDLE;
         endcase
      end
   end

   assign done = (state_q == MMOR_ALU_DONE);
   // Product high to aux, low to main; quotient to main, remainder to aux
   assign mainOut = isDiv_q ? quot_q : acc_q[7:0];
   assign auxOut = isDiv_q ? acc_q[7:0] : acc_q[15:8];
endmodule // mmor_muldiv

// *** mmor_regs.sv ***
// Purpose: APB slave with window control, bank select and operand registers
// Assumes: mode pins are asynchronous; core requests come on the same clock
// Notes: APB byte address = register index * 4; unmapped reads give zero, pslverr set
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "mmor_consts.svh"
module mmor_regs
   import mmor_pkg::*;
(
   // Clocking
   input wire logic clock,
   input wire logic rst,
   input wire logic clockEn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [1:0] mode_select_pins,
   // Core arithmetic request
   input wire logic opStart,
   input wire mmor_op_t opKind,
   output logic opBusy,
   // Fetch address mapping, main operand and bank select
   input wire logic [15:0] fetchAddr,
   output logic fetchFromRom,
   output logic [7:0] main_operand,
   output logic program_bank_select
);
   logic [1:0] pinMeta_q;
   logic [1:0] pinSync_q;
   logic in_system_program_flag_q;
   logic boot_rom_map_select_q;
   logic bank_q;
   logic [7:0] main_q;
   logic [7:0] aux_q;
   logic aluDone;
   logic [7:0] aluMain;
   logic [7:0] aluAux;
   logic apbAccess;
   logic apbWrite;
   logic hit;
   logic [7:0] readByte;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic opRun_q;

   function automatic logic isReg(input logic [11:0] a, input logic [7:0] idx);
      return (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
   endfunction

   // Ready is immediate: every access completes in its first access cycle
   assign apbAccess = psel && penable && clockEn;
   assign apbWrite = apbAccess && pwrite;
   assign pready = psel && penable;
   assign hit = isReg(paddr, `MMOR_IDX_BANK) || isReg(paddr, `MMOR_IDX_WIN) ||
                isReg(paddr, `MMOR_IDX_MAIN) || isReg(paddr, `MMOR_IDX_AUX);

   // Two flops; pins are asynchronous to the core clock
   always_ff @(posedge clock) begin
      if (rst) begin
         pinMeta_q <= 2'b00;
         pinSync_q <= 2'b00;
      end else if (clockEn) begin
         pinMeta_q <= mode_select_pins;
         pinSync_q <= pinMeta_q;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         in_system_program_flag_q <= 1'b0;
      end else if (clockEn) begin
         // Hardware owns this bit; writes never reach it
         in_system_program_flag_q <= (pinSync_q == `MMOR_ISP_CODE);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         boot_rom_map_select_q <= `MMOR_ROM_RST;
      end else if (apbWrite && isReg(paddr, `MMOR_IDX_WIN)) begin
         boot_rom_map_select_q <= pwdata[`MMOR_BIT_ROM];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bank_q <= `MMOR_BANK_RST;
      end else if (apbWrite && isReg(paddr, `MMOR_IDX_BANK)) begin
         bank_q <= pwdata[`MMOR_BIT_BANK];
      end
   end

   mmor_muldiv u_alu (
      .clock(clock),
      .rst(rst),
      .clockEn(clockEn),
      .start(opStart),
      .op(opKind),
      .mainIn(main_q),
      .auxIn(aux_q),
      .done(aluDone),
      .mainOut(aluMain),
      .auxOut(aluAux)
   );

   // Result write-back beats a same-cycle software write
   always_ff @(posedge clock) begin
      if (rst) begin
         main_q <= `MMOR_OPER_RST;
      end else if (clockEn && aluDone) begin
         main_q <= aluMain;
      end else if (apbWrite && isReg(paddr, `MMOR_IDX_MAIN)) begin
         main_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         aux_q <= `MMOR_OPER_RST;
      end else if (clockEn && aluDone) begin
         aux_q <= aluAux;
      end else if (apbWrite && isReg(paddr, `MMOR_IDX_AUX)) begin
         aux_q <= pwdata[7:0];
      end
   end

   always_comb begin
      readByte = 8'h00;
      if (isReg(paddr, `MMOR_IDX_WIN)) begin
         readByte[`MMOR_BIT_ISP] = in_system_program_flag_q;
         readByte[`MMOR_BIT_ROM] = boot_rom_map_select_q;
      end else if (isReg(paddr, `MMOR_IDX_BANK)) begin
         readByte[`MMOR_BIT_BANK] = bank_q;
      end else if (isReg(paddr, `MMOR_IDX_MAIN)) begin
         readByte = main_q;
      end else if (isReg(paddr, `MMOR_IDX_AUX)) begin
         readByte = aux_q;
      end
   end

   // Read data registered in the setup cycle so it is flop-driven in access
   always_ff @(posedge clock) begin
      if (rst) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (clockEn && psel && !penable) begin
         prdata_q <= {24'h000000, readByte};
         pslverr_q <= !hit;
      end
   end

   // Tracks the ALU run locally, so busy needs no look inside the child
   always_ff @(posedge clock) begin
      if (rst) begin
         opRun_q <= 1'b0;
      end else if (clockEn && aluDone) begin
         opRun_q <= 1'b0;
      end else if (clockEn && opStart && opKind != MMOR_OP_NONE) begin
         opRun_q <= 1'b1;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;
   assign opBusy = opStart || opRun_q;

   // Top 1KB goes to ROM only while the map bit is set
   assign fetchFromRom = boot_rom_map_select_q &&
                         (fetchAddr >= `MMOR_WIN_BASE);
   assign main_operand = main_q;
   assign program_bank_select = bank_q;

   property p_isp_follows_pins;
      @(posedge clock) disable iff (rst)
      clockEn [*3] ##0 (pinSync_q == `MMOR_ISP_CODE) |=> in_system_program_flag_q;
   endproperty
   a_isp_follows_pins: assert property (p_isp_follows_pins)
      else $error("isp flag not set for mode 3");

   property p_isp_clear;
      @(posedge clock) disable iff (rst)
      (clockEn && pinSync_q != `MMOR_ISP_CODE) |=> !in_system_program_flag_q;
   endproperty
   a_isp_clear: assert property (p_isp_clear)
      else $error("isp flag set without mode 3");

   property p_rom_map;
      @(posedge clock) disable iff (rst)
      (fetchAddr >= 16'hFC00) |-> (fetchFromRom == boot_rom_map_select_q);
   endproperty
   a_rom_map: assert property (p_rom_map)
      else $error("top window mapping wrong");

   property p_low_never_rom;
      @(posedge clock) disable iff (rst)
      (fetchAddr < 16'hFC00) |-> !fetchFromRom;
   endproperty
   a_low_never_rom: assert property (p_low_never_rom)
      else $error("low address mapped to rom");

   property p_win_write;
      @(posedge clock) disable iff (rst)
      (apbWrite && isReg(paddr, `MMOR_IDX_WIN)) |=>
         (boot_rom_map_select_q == $past(pwdata[1]));
   endproperty
   a_win_write: assert property (p_win_write)
      else $error("map bit write lost");

   property p_bank_write;
      @(posedge clock) disable iff (rst)
      (apbWrite && isReg(paddr, `MMOR_IDX_BANK)) |=> (bank_q == $past(pwdata[0]));
   endproperty
   a_bank_write: assert property (p_bank_write)
      else $error("bank write lost");

   property p_main_write;
      @(posedge clock) disable iff (rst)
      (apbWrite && isReg(paddr, `MMOR_IDX_MAIN) && !aluDone) |=>
         (main_q == $past(pwdata[7:0]));
   endproperty
   a_main_write: assert property (p_main_write)
      else $error("main operand write lost");

   property p_aux_write;
      @(posedge clock) disable iff (rst)
      (apbWrite && isReg(paddr, `MMOR_IDX_AUX) && !aluDone && !opBusy) |=>
         (aux_q == $past(pwdata[7:0]));
   endproperty
   a_aux_write: assert property (p_aux_write)
      else $error("aux operand write lost");

   property p_mul_result;
      logic [15:0] prod;
      @(posedge clock) disable iff (rst)
      (clockEn && opStart && opKind == MMOR_OP_MUL && !opRun_q && !apbWrite,
       prod = main_q * aux_q) ##1 (clockEn && !apbWrite) [*8] ##1 clockEn |=>
         ({aux_q, main_q} == prod);
   endproperty
   a_mul_result: assert property (p_mul_result)
      else $error("product bytes wrong");

   property p_reserved_zero;
      @(posedge clock) disable iff (rst)
      (psel && penable && $past(clockEn && psel && !penable) &&
       (isReg(paddr, `MMOR_IDX_WIN) || isReg(paddr, `MMOR_IDX_BANK))) |->
         (isReg(paddr, `MMOR_IDX_WIN) ? (prdata[31:3] == 29'h0 && !prdata[0]) :
            (prdata[31:1] == 31'h0));
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits read nonzero");
endmodule // mmor_regs

// *** tb_top.sv ***
// Purpose: self-checking bench for the memory-map and operand register block
// Assumes: zero-wait APB slave, byte address is four times the register index
// Notes: operands and fetch addresses drawn from a fixed seed, corner cases mixed in
`timescale 1ns/1ps
module tb_top
   import mmor_pkg::*;
;
   localparam logic [11:0] ADDR_BANK = 12'h284;
   localparam logic [11:0] ADDR_WIN = 12'h300;
   localparam logic [11:0] ADDR_MAIN = 12'h380;
   localparam logic [11:0] ADDR_AUX = 12'h3C0;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic clockEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] modePins = 2'h0;
   logic opStart = 1'b0;
   mmor_op_t opKind = MMOR_OP_NONE;
   logic [15:0] fetchAddr = 16'h0000;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, opBusy, fetchFromRom, programBank;
   wire logic [7:0] mainOperand;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   integer seed = 32'h6F53FB9C;
   logic [15:0] addrTab [6];
   logic [1:0] pinTab [5];

   mmor_regs DUT (.clock(clock), .rst(rst), .clockEn(clockEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_select_pins(modePins),
      .opStart(opStart), .opKind(opKind), .opBusy(opBusy), .fetchAddr(fetchAddr),
      .fetchFromRom(fetchFromRom), .main_operand(mainOperand),
      .program_bank_select(programBank));

   always #4 clock = ~clock;

   task automatic conclude;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Generous ceiling, the whole sequence needs well under a thousand cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("unexpected at %0t: timeout", $time);
         conclude;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // Entered just after a rising edge; one idle edge at the end keeps psel from toggling twice
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         n++;
         @(posedge clock);
      end
      check(n, 0, "pready wait");
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, {24'h0, d}, r, e);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      check(r, exp, what);
   endtask

   function automatic logic [31:0] winExp(input logic rom, input logic [1:0] pins);
      return {29'h0, pins == 2'h3, rom, 1'b0};
   endfunction

   function automatic logic [15:0] mulExp(input logic [15:0] a, input logic [15:0] b);
      return a * b;
   endfunction

   // Returns {remainder, quotient}; a zero divisor gives 0xFF and keeps the dividend
   function automatic logic [15:0] divExp(input logic [7:0] dvd, input logic [7:0] dvs);
      if (dvs == 8'h00)
         return {dvd, 8'hFF};
      return {dvd % dvs, dvd / dvs};
   endfunction

   task automatic resetValues;
      rd(ADDR_BANK, 32'h0, "bank reset");
      rd(ADDR_WIN, winExp(1'b1, modePins), "window reset");
      rd(ADDR_MAIN, 32'h0, "main reset");
      rd(ADDR_AUX, 32'h0, "aux reset");
   endtask

   task automatic arith(input mmor_op_t k, input logic [7:0] m, input logic [7:0] x);
      logic [15:0] e;
      e = (k == MMOR_OP_MUL) ? mulExp(m, x) : divExp(x, m);
      wr(ADDR_MAIN, m);
      wr(ADDR_AUX, x);
      opStart <= 1'b1;
      opKind <= k;
      @(posedge clock);
      opStart <= 1'b0;
      @(posedge clock);
      check(opBusy, 1'b1, "busy");
      while (opBusy === 1'b1) begin
         @(posedge clock);
      end
      check(mainOperand, e[7:0], "main pin");
      rd(ADDR_MAIN, {24'h0, e[7:0]}, "low result");
      rd(ADDR_AUX, {24'h0, e[15:8]}, "high result");
   endtask

   initial begin
      logic [31:0] r;
      logic e;
      logic [7:0] v;
      addrTab = '{16'hFBFF, 16'hFC00, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
      pinTab = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      resetValues;
      wr(ADDR_BANK, 8'hFF);
      rd(ADDR_BANK, 32'h1, "bank one");
      check(programBank, 1'b1, "bank pin");
      wr(ADDR_BANK, 8'hFE);
      rd(ADDR_BANK, 32'h0, "bank zero");
      wr(ADDR_WIN, 8'hFD);
      rd(ADDR_WIN, winExp(1'b0, 2'h0), "window reserved");
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_WIN, {6'h0, m[0], 1'b0});
         for (int i = 0; i < 6; i++) begin
            fetchAddr <= (i > 3) ? 16'($random(seed)) : addrTab[i];
            @(posedge clock);
            check(fetchFromRom, m[0] && fetchAddr >= 16'hFC00, "map");
         end
      end
      foreach (pinTab[i]) begin
         modePins <= pinTab[i];
         repeat (4) @(posedge clock);
         rd(ADDR_WIN, winExp(1'b1, pinTab[i]), "isp flag");
      end
      apb(1'b0, 12'h004, 32'h0, r, e);
      check(r, 32'h0, "unmapped read data");
      check(e, 1'b1, "unmapped read error");
      apb(1'b1, 12'h381, 32'hFF, r, e);
      check(e, 1'b1, "misaligned write");
      rd(ADDR_MAIN, 32'h0, "write dropped");
      v = 8'($random(seed));
      wr(ADDR_AUX, v);
      rd(ADDR_AUX, {24'h0, v}, "aux rw");
      wr(ADDR_MAIN, ~v);
      rd(ADDR_MAIN, {24'h0, ~v}, "main rw");
      clockEn <= 1'b0;
      wr(ADDR_MAIN, v);
      clockEn <= 1'b1;
      rd(ADDR_MAIN, {24'h0, ~v}, "frozen write");
      // A start with no operation must not begin a run
      opStart <= 1'b1;
      opKind <= MMOR_OP_NONE;
      @(posedge clock);
      opStart <= 1'b0;
      @(posedge clock);
      check(opBusy, 1'b0, "none ignored");
      rd(ADDR_MAIN, {24'h0, ~v}, "none keeps main");
      arith(MMOR_OP_MUL, 8'hFF, 8'hFF);
      arith(MMOR_OP_DIV, 8'h00, 8'h37);
      arith(MMOR_OP_DIV, 8'h01, 8'hFF);
      arith(MMOR_OP_DIV, 8'hFF, 8'h0A);
      repeat (24) begin
         arith(($random(seed) & 1) ? MMOR_OP_MUL : MMOR_OP_DIV, 8'($random(seed)),
            8'($random(seed)));
      end
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      resetValues;
      conclude;
   end
endmodule // tb_top
